// ==== lane_si_pkg.sv ====
package lane_si_pkg;
	// ****************************************
	// sizes and bus identity
	// ****************************************
	localparam int LANES = 8;
	localparam logic [6:0] DEV_ADDR = 7'h50;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_LB_CAP = 8'h80;
	localparam logic [7:0] OFS_RX_EQ = 8'h90;
	localparam logic [7:0] OFS_RX_AMP = 8'h94;
	localparam logic [7:0] OFS_TX_DIS = 8'h98;
	localparam logic [7:0] OFS_HOST_LB = 8'h99;
	localparam logic [7:0] OFS_MEDIA_LB = 8'h9A;
	localparam logic [7:0] OFS_TX_PWR = 8'hA0;
	// ****************************************
	// fixed and reset values
	// ****************************************
	localparam logic [7:0] LB_CAP_VALUE = 8'h3F;
	localparam logic [3:0] RX_EQ_RST = 4'h1;
	localparam logic [3:0] RX_AMP_RST = 4'h2;
	localparam logic [3:0] RX_EQ_MAX_STD = 4'h7;
	localparam logic [3:0] RX_EQ_MIN_CUSTOM = 4'hB;
	localparam logic [3:0] RX_AMP_MAX_STD = 4'h3;
	localparam logic [3:0] RX_AMP_CUSTOM = 4'hF;
	// 0.1 uW units, so one count is -40 dBm
	localparam logic [15:0] TX_PWR_OFF = 16'h0001;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} mgmt_wr_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_AACK = 3'h3,
		ST_DATA = 3'h2,
		ST_DACK = 3'h6,
		ST_RDAT = 3'h7,
		ST_RACK = 3'h5
	} twi_state_e;
endpackage

// ==== twi_slave.sv ====
`timescale 1ns/1ps
module twi_slave
	import lane_si_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe,
	output lane_si_pkg::mgmt_wr_s wr_req,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	logic scl_d, sda_d, next_scl_d, next_sda_d;
	twi_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] sh, next_sh, tx, next_tx, ptr, next_ptr;
	logic rw, next_rw, first, next_first, nack, next_nack;
	logic next_sda_oe;
	mgmt_wr_s next_wr_req;
	logic rise, fall, start, stop;

	assign rise = scl & ~scl_d;
	assign fall = ~scl & scl_d;
	assign start = scl & scl_d & sda_d & ~sda;
	assign stop = scl & scl_d & ~sda_d & sda;
	assign rd_addr = ptr;

	always_comb begin
		next_scl_d = scl;
		next_sda_d = sda;
		next_state = state;
		next_cnt = cnt;
		next_sh = sh;
		next_tx = tx;
		next_ptr = ptr;
		next_rw = rw;
		next_first = first;
		next_nack = nack;
		next_sda_oe = sda_oe;
		next_wr_req = '0;
		next_wr_req.addr = ptr;
		next_wr_req.data = sh;
		if (start) begin
			next_state = ST_ADDR;
			next_cnt = '0;
			next_first = 1'b1;
			next_sda_oe = 1'b0;
		end else if (stop) begin
			next_state = ST_IDLE;
			next_sda_oe = 1'b0;
		end else if (rise) begin
			if (state == ST_ADDR || state == ST_DATA) begin
				next_sh = {sh[6:0], sda};
				next_cnt = cnt + 4'h1;
			end else if (state == ST_RDAT) begin
				next_cnt = cnt + 4'h1;
			end else if (state == ST_RACK) begin
				next_nack = sda;
			end
		end else if (fall) begin
			case (state)
				ST_ADDR: begin
					// only the fixed bus address is answered
					if (cnt == BITS_PER_BYTE) begin
						if (sh[7:1] == DEV_ADDR) begin
							next_state = ST_AACK;
							next_rw = sh[0];
							next_sda_oe = 1'b1;
						end else begin
							next_state = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					next_cnt = '0;
					if (rw) begin
						next_state = ST_RDAT;
						next_tx = rd_data;
						next_sda_oe = ~rd_data[7];
					end else begin
						next_state = ST_DATA;
						next_sda_oe = 1'b0;
					end
				end
				ST_DATA: begin
					if (cnt == BITS_PER_BYTE) begin
						next_state = ST_DACK;
						next_sda_oe = 1'b1;
						next_first = 1'b0;
						if (first) begin
							next_ptr = sh;
						end else begin
							next_wr_req.wr = 1'b1;
							next_ptr = ptr + 8'h01;
						end
					end
				end
				ST_DACK: begin
					next_state = ST_DATA;
					next_cnt = '0;
					next_sda_oe = 1'b0;
				end
				ST_RDAT: begin
					if (cnt == BITS_PER_BYTE) begin
						// pointer moves now so the next byte is ready at ack
						next_state = ST_RACK;
						next_sda_oe = 1'b0;
						next_ptr = ptr + 8'h01;
					end else begin
						next_tx = {tx[6:0], 1'b1};
						next_sda_oe = ~tx[6];
					end
				end
				ST_RACK: begin
					if (nack) begin
						next_state = ST_IDLE;
					end else begin
						next_state = ST_RDAT;
						next_cnt = '0;
						next_tx = rd_data;
						next_sda_oe = ~rd_data[7];
					end
				end
				default: begin
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= ST_IDLE;
			cnt <= '0;
			sh <= '0;
			tx <= '0;
			ptr <= '0;
			rw <= 1'b0;
			first <= 1'b0;
			nack <= 1'b0;
			sda_oe <= 1'b0;
			wr_req <= '0;
		end else begin
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
			state <= next_state;
			cnt <= next_cnt;
			sh <= next_sh;
			tx <= next_tx;
			ptr <= next_ptr;
			rw <= next_rw;
			first <= next_first;
			nack <= next_nack;
			sda_oe <= next_sda_oe;
			wr_req <= next_wr_req;
		end
	end
endmodule

// ==== lane_signal_integrity_loopback_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - adaptive transmit equalization starts itself after reset
// - transmit adaptive equalization can never be disabled
// - receive equalization field read/write, resets to 1
// - eq codes 0-7 standard, 8-10 reserved, 11-15 custom
// - receive amplitude code resets to 2
// - amplitude 0-3 standard, 4-14 reserved, 15 custom
// - host and media input loopback, media enable clears host
// - capability bit 6 reads zero
// - capability bits 5 and 4 read one
// - capability bits 3 to 0 read one
// - disabled transmitter reports -40 dBm power
// - host asks low power, device shows presence
// - device raises interrupt, host commands reset
// - management answers at bus address 1010000
module lane_signal_integrity_loopback_ctrl
	import lane_si_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda,
	output logic sda_drive,
	output logic sda_oe,
	input wire logic low_power_presence_req,
	output logic low_power_presence_present,
	output logic low_power_mode,
	input wire logic interrupt_reset_cmd_n,
	output logic interrupt_reset_irq,
	input wire logic irq_event,
	input wire logic [lane_si_pkg::LANES*16-1:0] tx_power_meas,
	output logic [lane_si_pkg::LANES-1:0] tx_adapt_en,
	output logic [lane_si_pkg::LANES-1:0] tx_adapt_start,
	output logic [lane_si_pkg::LANES*4-1:0] rx_eq,
	output logic [lane_si_pkg::LANES-1:0] rx_eq_custom,
	output logic [lane_si_pkg::LANES*4-1:0] rx_amp,
	output logic [lane_si_pkg::LANES-1:0] rx_amp_custom,
	output logic [lane_si_pkg::LANES-1:0] tx_disable,
	output logic [lane_si_pkg::LANES-1:0] host_in_loopback,
	output logic [lane_si_pkg::LANES-1:0] media_in_loopback
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [3:0] sync1, sync2;
	logic scl_s, sda_s, lp_s, rst_cmd_n_s, mrst, mrst_d;

	always_ff @(posedge clk) begin
		if (srst) begin
			// lp idles low: no false low-power request after reset
			sync1 <= 4'hD;
			sync2 <= 4'hD;
		end else begin
			sync1 <= {scl, sda, low_power_presence_req,
				interrupt_reset_cmd_n};
			sync2 <= sync1;
		end
	end
	assign {scl_s, sda_s, lp_s, rst_cmd_n_s} = sync2;
	// host reset command acts like the local reset
	assign mrst = srst | ~rst_cmd_n_s;

	// ****************************************
	// management slave
	// ****************************************
	mgmt_wr_s wr_req;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;

	twi_slave u_twi (
		.clk(clk),
		.srst(mrst),
		.scl(scl_s),
		.sda(sda_s),
		.sda_oe(sda_oe),
		.wr_req(wr_req),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);
	// open-drain: only ever pulls low
	assign sda_drive = 1'b0;

	// ****************************************
	// code checks
	// ****************************************
	function automatic logic eq_ok(input logic [3:0] c);
		eq_ok = (c <= RX_EQ_MAX_STD) || (c >= RX_EQ_MIN_CUSTOM);
	endfunction
	function automatic logic amp_ok(input logic [3:0] c);
		amp_ok = (c <= RX_AMP_MAX_STD) || (c == RX_AMP_CUSTOM);
	endfunction

	// ****************************************
	// control registers
	// ****************************************
	logic [LANES*4-1:0] next_rx_eq, next_rx_amp;
	logic [LANES-1:0] next_tx_dis, next_host_lb, next_media_lb;
	logic [LANES-1:0] next_adapt_start, next_eq_custom, next_amp_custom;
	logic next_present, next_lp_mode, next_irq;
	logic [3:0] nib;
	logic [7:0] eq_ofs, amp_ofs;

	always_comb begin
		next_rx_eq = rx_eq;
		next_rx_amp = rx_amp;
		next_tx_dis = tx_disable;
		next_host_lb = host_in_loopback;
		next_media_lb = media_in_loopback;
		nib = '0;
		eq_ofs = '0;
		amp_ofs = '0;
		for (int l = 0; l < LANES; l++) begin
			eq_ofs = OFS_RX_EQ + 8'(l / 2);
			amp_ofs = OFS_RX_AMP + 8'(l / 2);
			nib = (l % 2 == 1) ? wr_req.data[7:4] : wr_req.data[3:0];
			// reserved codes leave the old setting in place
			if (wr_req.wr && wr_req.addr == eq_ofs && eq_ok(nib)) begin
				next_rx_eq[l*4 +: 4] = nib;
			end
			if (wr_req.wr && wr_req.addr == amp_ofs && amp_ok(nib)) begin
				next_rx_amp[l*4 +: 4] = nib;
			end
		end
		if (wr_req.wr && wr_req.addr == OFS_TX_DIS) begin
			next_tx_dis = wr_req.data;
		end
		// loopbacks are enabled by host writes
		if (wr_req.wr && wr_req.addr == OFS_HOST_LB) begin
			next_host_lb = wr_req.data;
		end
		if (wr_req.wr && wr_req.addr == OFS_MEDIA_LB) begin
			next_media_lb = wr_req.data;
		end
		// no simultaneous loopback: a media enable clears host
		next_host_lb = next_host_lb & ~next_media_lb;
		for (int l = 0; l < LANES; l++) begin
			next_eq_custom[l] = next_rx_eq[l*4 +: 4] >= RX_EQ_MIN_CUSTOM;
			next_amp_custom[l] = next_rx_amp[l*4 +: 4] == RX_AMP_CUSTOM;
		end
		// one start pulse per lane when reset lets go
		next_adapt_start = {LANES{mrst_d}};
		next_present = 1'b1;
		next_lp_mode = lp_s;
		next_irq = irq_event;
	end

	always_ff @(posedge clk) begin
		mrst_d <= mrst;
		if (mrst) begin
			rx_eq <= {LANES{RX_EQ_RST}};
			rx_amp <= {LANES{RX_AMP_RST}};
			tx_disable <= '0;
			host_in_loopback <= '0;
			media_in_loopback <= '0;
			rx_eq_custom <= '0;
			rx_amp_custom <= '0;
			tx_adapt_start <= '0;
			low_power_presence_present <= 1'b1;
			low_power_mode <= 1'b0;
			interrupt_reset_irq <= 1'b0;
		end else begin
			rx_eq <= next_rx_eq;
			rx_amp <= next_rx_amp;
			tx_disable <= next_tx_dis;
			host_in_loopback <= next_host_lb;
			media_in_loopback <= next_media_lb;
			rx_eq_custom <= next_eq_custom;
			rx_amp_custom <= next_amp_custom;
			tx_adapt_start <= next_adapt_start;
			low_power_presence_present <= next_present;
			low_power_mode <= next_lp_mode;
			interrupt_reset_irq <= next_irq;
		end
	end
	// there is no register to reach this: adaptive stays on
	assign tx_adapt_en = {LANES{1'b1}};

	// ****************************************
	// read path
	// ****************************************
	logic [15:0] pwr_word;
	logic [2:0] pwr_lane;
	logic [1:0] byte_sel;

	always_comb begin
		pwr_lane = rd_addr[3:1];
		// both code fields sit on four-byte boundaries
		byte_sel = rd_addr[1:0];
		// a dark transmitter shows the floor value
		pwr_word = tx_disable[pwr_lane] ? TX_PWR_OFF :
			tx_power_meas[{pwr_lane, 4'h0} +: 16];
		rd_data = '0;
		if (rd_addr == OFS_LB_CAP) begin
			rd_data = LB_CAP_VALUE;
		end else if (rd_addr >= OFS_RX_EQ && rd_addr < OFS_RX_AMP) begin
			rd_data = rx_eq[{byte_sel, 3'h0} +: 8];
		end else if (rd_addr >= OFS_RX_AMP && rd_addr < OFS_TX_DIS) begin
			rd_data = rx_amp[{byte_sel, 3'h0} +: 8];
		end else if (rd_addr == OFS_TX_DIS) begin
			rd_data = tx_disable;
		end else if (rd_addr == OFS_HOST_LB) begin
			rd_data = host_in_loopback;
		end else if (rd_addr == OFS_MEDIA_LB) begin
			rd_data = media_in_loopback;
		end else if (rd_addr[7:4] == OFS_TX_PWR[7:4]) begin
			rd_data = rd_addr[0] ? pwr_word[7:0] : pwr_word[15:8];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_lb_cap_value: assert property (@(posedge clk) disable iff (srst)
		rd_addr == OFS_LB_CAP |-> rd_data[6] == 1'b0 &&
		rd_data[5:0] == 6'h3F)
		else $error("loopback capability byte wrong");
	a_eq_reset_val: assert property (@(posedge clk) disable iff (srst)
		$fell(mrst) |-> rx_eq == {LANES{4'h1}})
		else $error("rx eq not at 1 dB after reset");
	a_amp_reset_val: assert property (@(posedge clk) disable iff (srst)
		$fell(mrst) |-> rx_amp == {LANES{4'h2}})
		else $error("rx amplitude not 2 after reset");
	a_eq_reserved_kept: assert property (@(posedge clk) disable iff (mrst)
		wr_req.wr && wr_req.addr == OFS_RX_EQ &&
		wr_req.data[3:0] inside {4'h8, 4'h9, 4'hA}
		|=> rx_eq[3:0] == $past(rx_eq[3:0]))
		else $error("reserved eq code was taken");
	a_amp_reserved_kept: assert property (@(posedge clk) disable iff (mrst)
		wr_req.wr && wr_req.addr == OFS_RX_AMP + 8'h02 &&
		wr_req.data[3:0] > 4'h3 && wr_req.data[3:0] < 4'hF
		|=> rx_amp[19:16] == $past(rx_amp[19:16]))
		else $error("reserved amplitude code was taken");
	a_eq_write_taken: assert property (@(posedge clk) disable iff (mrst)
		wr_req.wr && wr_req.addr == OFS_RX_EQ + 8'h02 &&
		wr_req.data[3:0] == 4'h5
		|=> rx_eq[19:16] == 4'h5 ##1 rx_eq_custom[4] == 1'b0)
		else $error("valid eq code not stored");
	a_tx_off_power: assert property (@(posedge clk) disable iff (srst)
		tx_disable[rd_addr[3:1]] && rd_addr[7:4] == 4'hA
		|-> rd_data == (rd_addr[0] ? 8'h01 : 8'h00))
		else $error("disabled lane power not floor");
	a_adapt_always: assert property (@(posedge clk) disable iff (srst)
		tx_adapt_en == {LANES{1'b1}})
		else $error("adaptive eq turned off");
	a_adapt_kick: assert property (@(posedge clk) disable iff (srst)
		$fell(mrst) |=> tx_adapt_start == {LANES{1'b1}} ##1
		tx_adapt_start == '0)
		else $error("adaptive start pulse missing");
	a_lb_exclusive: assert property (@(posedge clk) disable iff (srst)
		(host_in_loopback & media_in_loopback) == '0)
		else $error("host and media loopback both on");
endmodule

// ==== mgmt_host.sv ====
`timescale 1ns/1ps
module mgmt_host (
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	import lane_si_pkg::*;
	// ****************************************
	// two-wire host, quarter steps of a 125 ns bit
	// ****************************************
	// scl stands high between frames; a released sda reads the pull-up
	localparam real Q = 31.25;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bit_io(input logic tx, output logic rx);
		#Q sda_pull = ~tx;
		#Q scl = 1'b1;
		#Q rx = sda;
		#Q scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
	endtask
	task automatic send(input logic [7:0] b, output logic nack);
		logic [7:0] junk;
		byte_io(b, junk);
		bit_io(1'b1, nack);
	endtask
	task automatic start();
		// a repeated start first releases sda while scl is low, then raises scl
		if (!scl) begin
			#Q sda_pull = 1'b0;
			#Q scl = 1'b1;
		end
		#Q sda_pull = 1'b1;
		#Q scl = 1'b0;
	endtask
	task automatic stop();
		#Q sda_pull = 1'b1;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b0;
		#(2 * Q);
	endtask
	task automatic access(input logic [6:0] dev, input logic rd,
			input logic [7:0] ptr, input logic [7:0] wd,
			output logic [7:0] rdat, output logic ok);
		logic n0, n1, n2, nk;
		start();
		send({dev, 1'b0}, n0);
		send(ptr, n1);
		if (rd) begin
			start();
			send({dev, 1'b1}, n2);
			byte_io(8'hFF, rdat);
			bit_io(1'b1, nk);
		end else begin
			send(wd, n2);
			rdat = 8'h00;
		end
		stop();
		ok = !(n0 || n1 || n2);
	endtask
endmodule

// ==== tb_lane_signal_integrity_loopback_ctrl.sv ====
`timescale 1ns/1ps
module tb_lane_signal_integrity_loopback_ctrl;
	import lane_si_pkg::*;
	logic clk = 1'b0, srst = 1'b1, lp_req = 1'b0, cmd_n = 1'b1, irq_ev = 1'b0;
	logic [LANES*16-1:0] meas;
	logic sda_drive, sda_oe, present, lp_mode, irq, scl, host_pull, ok;
	logic [7:0] adapt_en, adapt_start, eq_cus, amp_cus, tx_dis, hlb, mlb, rd;
	logic [31:0] rx_eq, rx_amp;
	logic [3:0] prev_eq, prev_amp;
	int n_errors = 0, n_compared = 0, n_pulse = 0;
	wire sda_w = !(host_pull || (sda_oe && !sda_drive));
	// ****************************************
	// ordinary cases: read rows carry the expected byte
	// ****************************************
	mgmt_wr_s rows [28] = '{
		'{1'b0, 8'h80, 8'h3F}, '{1'b1, 8'h80, 8'h00},
		'{1'b0, 8'h80, 8'h3F}, '{1'b0, 8'h90, 8'h11},
		'{1'b0, 8'h93, 8'h11}, '{1'b0, 8'h94, 8'h22},
		'{1'b0, 8'h97, 8'h22}, '{1'b1, 8'h90, 8'h73},
		'{1'b0, 8'h90, 8'h73}, '{1'b1, 8'h90, 8'h98},
		'{1'b0, 8'h90, 8'h73}, '{1'b1, 8'h91, 8'hBA},
		'{1'b0, 8'h91, 8'hB1}, '{1'b1, 8'h94, 8'h4F},
		'{1'b0, 8'h94, 8'h2F}, '{1'b1, 8'h95, 8'h30},
		'{1'b0, 8'h95, 8'h30}, '{1'b0, 8'hC0, 8'h00},
		'{1'b1, 8'h98, 8'h01}, '{1'b0, 8'h98, 8'h01},
		'{1'b0, 8'hA0, 8'h00}, '{1'b0, 8'hA1, 8'h01},
		'{1'b0, 8'hA2, 8'h12}, '{1'b0, 8'hA3, 8'h34},
		'{1'b1, 8'h99, 8'hFF}, '{1'b1, 8'h9A, 8'h01},
		'{1'b0, 8'h99, 8'hFE}, '{1'b0, 8'h9A, 8'h01}
	};
	always #5 clk = ~clk;
	always @(posedge clk) if (adapt_start === 8'hFF) n_pulse++;
	lane_signal_integrity_loopback_ctrl DUT (.clk(clk), .srst(srst),
		.scl(scl), .sda(sda_w), .sda_drive(sda_drive), .sda_oe(sda_oe),
		.low_power_presence_req(lp_req), .low_power_presence_present(present),
		.low_power_mode(lp_mode), .interrupt_reset_cmd_n(cmd_n),
		.interrupt_reset_irq(irq), .irq_event(irq_ev), .tx_power_meas(meas),
		.tx_adapt_en(adapt_en), .tx_adapt_start(adapt_start), .rx_eq(rx_eq),
		.rx_eq_custom(eq_cus), .rx_amp(rx_amp), .rx_amp_custom(amp_cus),
		.tx_disable(tx_dis), .host_in_loopback(hlb), .media_in_loopback(mlb));
	mgmt_host HOST (.scl(scl), .sda_pull(host_pull), .sda(sda_w));
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t port got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		HOST.access(DEV_ADDR, !w, a, d, rd, ok);
		chk_byte({7'h00, ok}, 8'h01);
		if (!w) chk_byte(rd, d);
		cyc(2);
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#800us;
		n_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		test_done();
	end
	initial begin
		meas = {LANES{16'h0500}};
		meas[31:16] = 16'h1234;
		cyc(20);
		srst = 1'b0;
		cyc(2);
		chk_port(lp_mode, 0);
		cyc(6);
		chk_port(n_pulse, 1);
		chk_port(adapt_en, 8'hFF);
		chk_port(rx_eq, 32'h11111111);
		chk_port(rx_amp, 32'h22222222);
		chk_port(present, 1);
		lp_req = 1'b1;
		irq_ev = 1'b1;
		cyc(8);
		chk_port(lp_mode, 1);
		chk_port(irq, 1);
		lp_req = 1'b0;
		irq_ev = 1'b0;
		cyc(8);
		chk_port({lp_mode, irq}, 0);
		$display("test reset and sidebands done");
		for (int i = 0; i < 28; i++) begin
			bus(rows[i].wr, rows[i].addr, rows[i].data);
		end
		chk_port(rx_eq, 32'h1111B173);
		chk_port(rx_amp, 32'h2222302F);
		chk_port({eq_cus, amp_cus}, 16'h0801);
		chk_port({tx_dis, hlb, mlb}, 24'h01FE01);
		chk_port(adapt_en, 8'hFF);
		$display("test register rows done");
		HOST.access(7'h51, 1'b1, 8'h80, 8'h00, rd, ok);
		chk_byte({7'h00, ok}, 8'h00);
		cyc(4);
		prev_eq = 4'h1;
		prev_amp = 4'h2;
		for (int c = 0; c < 16; c++) begin
			bus(1'b1, OFS_RX_EQ + 8'h02, {4'h1, c[3:0]});
			bus(1'b1, OFS_RX_AMP + 8'h02, {4'h2, c[3:0]});
			if (c < 8 || c > 10) prev_eq = c[3:0];
			if (c < 4 || c == 15) prev_amp = c[3:0];
			bus(1'b0, OFS_RX_EQ + 8'h02, {4'h1, prev_eq});
			bus(1'b0, OFS_RX_AMP + 8'h02, {4'h2, prev_amp});
			chk_port(eq_cus[4], prev_eq >= 4'hB);
			chk_port(amp_cus[4], prev_amp == 4'hF);
		end
		$display("test code sweep done");
		cmd_n = 1'b0;
		cyc(6);
		chk_port(rx_eq, 32'h11111111);
		chk_port({hlb, mlb, tx_dis}, 0);
		cmd_n = 1'b1;
		cyc(10);
		chk_port(n_pulse, 2);
		bus(1'b0, OFS_RX_AMP, 8'h22);
		$display("test module reset done");
		test_done();
	end
endmodule
